// File: logic/acd_defines.svh
// constants for the command decoder and status block
// assumes inclusion by bare name, definitions only
`ifndef ACD_DEFINES_SVH
`define ACD_DEFINES_SVH
`define ACD_SEL_STATUS 4'h0
`define ACD_SEL_CONVERTER_CONTROL_ONE 4'h1
`define ACD_SEL_GPIO_DIRECTION_VALUE 4'h2
`define ACD_SEL_GAIN_AND_CAL_ENABLE 4'h3
`define ACD_SEL_DATA 4'h4
`define ACD_SEL_SOC 4'h5
`define ACD_SEL_SGC 4'h6
`define ACD_SEL_SELF_OFFSET_COEFF 4'h7
`define ACD_SEL_SELF_GAIN_COEFF 4'h8
`define ACD_RST_STATUS 8'h00
`define ACD_RST_CONVERTER_CONTROL_ONE 8'h02
`define ACD_RST_GPIO_DIRECTION_VALUE 8'h0f
`define ACD_RST_GAIN_AND_CAL_ENABLE 8'h1e
`define ACD_RST_WIDE 24'h00_0000
`define ACD_BIT_START 7
`define ACD_BIT_MODE 6
`define ACD_BIT_PWDN 3
`define ACD_BIT_RW 0
`define ACD_CAL_SELF 2'h1
`define ACD_CAL_SYSOFF 2'h2
`define ACD_CAL_SYSGAIN 2'h3
`define ACD_SGC_MAX 24'hff_ffff
`define ACD_WIDE_BITS 24
`define ACD_NARROW_BITS 8
`endif

// File: logic/acd_pkg.sv
// types shared by the command decoder and its serial shifter
// assumes nothing beyond a SystemVerilog compiler
package acd_pkg;
	typedef struct packed {
		logic start;
		logic mode;
		logic [1:0] cal;
		logic pwdn;
		logic [2:0] rate;
	} acd_cmd_s;
	typedef struct packed {
		logic cal_over;
		logic [2:0] rate;
		logic over;
		logic under;
		logic busy;
		logic ready;
	} acd_status_s;
	typedef enum logic [3:0] {
		ACD_IDLE = 4'b0001,
		ACD_CMD = 4'b0010,
		ACD_WR = 4'b0100,
		ACD_RD = 4'b1000
	} acd_state_e;
endpackage

// File: logic/acd_link.sv
// serial link front end: synchronises pins, finds clock edges
// assumes sys_clk much faster than the serial clock
`timescale 1ns/1ns
`default_nettype none
module acd_link
	import acd_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic sclk_pin,
	input wire logic cs_n_pin,
	input wire logic din_pin,
	output logic cs_n,
	output logic din,
	output logic rise,
	output logic fall
);
	logic [1:0] sclk_sync;
	logic [1:0] cs_sync;
	logic [1:0] din_sync;
	logic sclk_prev;
	// two stages each before any logic looks
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			// serial clock idles high, so no false edge after reset
			sclk_sync <= 2'h3;
			cs_sync <= 2'h3;
			din_sync <= 2'h0;
			sclk_prev <= 1'b1;
		end else begin
			sclk_sync <= {sclk_sync[0], sclk_pin};
			cs_sync <= {cs_sync[0], cs_n_pin};
			din_sync <= {din_sync[0], din_pin};
			sclk_prev <= sclk_sync[1];
		end
	end
	assign cs_n = cs_sync[1];
	assign din = din_sync[1];
	assign rise = !cs_sync[1] && sclk_sync[1] && !sclk_prev; // [RULE19]
	assign fall = !cs_sync[1] && !sclk_sync[1] && sclk_prev; // [RULE19]
endmodule
`default_nettype wire

// File: logic/acd_core.sv
// command interpreter and register map for the converter
// assumes modulator results arrive as pulses on sys_clk
// Summary of operation
// RULE1 - mode bit zero makes the byte an action command
// RULE2 - mode bit one makes the byte a register read or write
// RULE3 - calibration field 01/10/11 starts self, offset, gain calibration
// RULE4 - power-down bit set with other fields zero powers down now
// RULE5 - all-zero cal and power-down starts conversion at chosen rate
// RULE6 - selects 0 to 8 address nine registers, 8 or 24 bits
// RULE7 - gain bits steer gain only on the gain-capable variant
// RULE8 - gain calibration overrange sets the calibration overrange flag
// RULE9 - status rate is the rate of held result or calibration
// RULE10 - result above maximum is clipped and sets overrange
// RULE11 - result below minimum is clipped and sets underrange
// RULE12 - busy flag is high while modulator converts or calibrates
// RULE13 - ready flag sets when a result lands in data register
// RULE14 - read before next start clears ready only at that start
// RULE15 - read during following conversion clears ready on completion
// RULE16 - status is read-only and resets to zero
// RULE17 - every command byte carries a set start bit in bit 7
// RULE18 - host places fields in the documented bit positions
// RULE19 - sample on rising clock, shift on falling, msb first
// RULE20 - data read shifts 24 result bits out msb first
// RULE21 - selects above eight and status writes are ignored
`timescale 1ns/1ns
`default_nettype none
`include "acd_defines.svh"
module acd_core
	import acd_pkg::*;
#(
	parameter bit HAS_GAIN = 1'b1,
	parameter int RES_BITS = 18
)
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic sclk_pin,
	input wire logic cs_n_pin,
	input wire logic din_pin,
	output logic dout,
	output logic dout_oe,
	output logic start_conv,
	output logic start_cal,
	output logic [1:0] cal_kind,
	output logic [2:0] conv_rate,
	output logic powerdown,
	input wire logic mod_done,
	input wire logic [23:0] mod_result,
	input wire logic mod_over,
	input wire logic mod_under,
	input wire logic cal_done,
	input wire logic cal_gain_over,
	output logic [7:0] control_one,
	output logic [7:0] gpio_ctrl,
	output logic [2:0] gain_sel,
	output logic [3:0] coeff_disable
);
	logic cs_n;
	logic din;
	logic rise;
	logic fall;
	acd_state_e state;
	logic [7:0] shift_in;
	logic [4:0] bit_cnt;
	logic [23:0] shift_out;
	logic [3:0] sel;
	logic [7:0] conv_status_raw;
	acd_status_s conv_status;
	logic [7:0] gain_and_cal_enable;
	logic [23:0] conversion_result;
	logic [23:0] system_offset_coeff;
	logic [23:0] system_gain_coeff;
	logic [23:0] self_offset_coeff;
	logic [23:0] self_gain_coeff;
	logic [2:0] pend_rate;
	logic busy_cal;
	logic read_seen;
	logic data_read_done;
	logic byte_done;
	acd_cmd_s cmd;
	logic [4:0] width_sel;
	logic [23:0] read_val;
	logic [23:0] max_code;
	logic [7:0] next_byte;

	acd_link u_link (
		.sys_clk(sys_clk),
		.rst(rst),
		.sclk_pin(sclk_pin),
		.cs_n_pin(cs_n_pin),
		.din_pin(din_pin),
		.cs_n(cs_n),
		.din(din),
		.rise(rise),
		.fall(fall)
	);

	assign max_code = 24'((25'h1 << RES_BITS) - 25'h1);
	assign next_byte = {shift_in[6:0], din};
	assign byte_done = rise && bit_cnt == 5'd7;
	assign cmd = acd_cmd_s'(next_byte);
	assign width_sel = (sel < `ACD_SEL_DATA) ? 5'd8 : 5'd24; // [RULE6]
	assign conv_status_raw = conv_status;

	// read mux; narrow registers sit in the top byte for msb-first shift
	always_comb begin
		read_val = 24'h00_0000;
		if (next_byte[4:1] == `ACD_SEL_STATUS) begin
			read_val = {conv_status_raw, 16'h0000};
		end else if (next_byte[4:1] == `ACD_SEL_CONVERTER_CONTROL_ONE) begin
			read_val = {control_one, 16'h0000};
		end else if (next_byte[4:1] == `ACD_SEL_GPIO_DIRECTION_VALUE) begin
			read_val = {gpio_ctrl, 16'h0000};
		end else if (next_byte[4:1] == `ACD_SEL_GAIN_AND_CAL_ENABLE) begin
			read_val = {gain_and_cal_enable, 16'h0000};
		end else if (next_byte[4:1] == `ACD_SEL_DATA) begin
			read_val = conversion_result; // [RULE20]
		end else if (next_byte[4:1] == `ACD_SEL_SOC) begin
			read_val = system_offset_coeff;
		end else if (next_byte[4:1] == `ACD_SEL_SGC) begin
			read_val = system_gain_coeff;
		end else if (next_byte[4:1] == `ACD_SEL_SELF_OFFSET_COEFF) begin
			read_val = self_offset_coeff;
		end else if (next_byte[4:1] == `ACD_SEL_SELF_GAIN_COEFF) begin
			read_val = self_gain_coeff;
		end
	end

	// frame state; chip select high aborts whatever was in flight
	always_ff @(posedge sys_clk) begin
		if (rst || cs_n) begin
			state <= ACD_CMD;
			shift_in <= 8'h00;
			bit_cnt <= 5'd0;
			sel <= 4'h0;
		end else if (rise) begin
			shift_in <= next_byte; // [RULE19]
			case (state)
			ACD_CMD: begin
				if (bit_cnt == 5'd7) begin
					bit_cnt <= 5'd0;
					sel <= next_byte[4:1];
					if (!next_byte[`ACD_BIT_START] || !cmd.mode) begin
						state <= ACD_IDLE; // [RULE1] [RULE17]
					end else if (next_byte[4:1] > `ACD_SEL_SELF_GAIN_COEFF) begin
						state <= ACD_IDLE; // [RULE21]
					end else if (next_byte[`ACD_BIT_RW]) begin
						state <= ACD_RD; // [RULE2]
					end else begin
						state <= ACD_WR; // [RULE2]
					end
				end else begin
					bit_cnt <= bit_cnt + 5'd1;
				end
			end
			ACD_WR, ACD_RD: begin
				if (bit_cnt == width_sel - 5'd1) begin
					state <= ACD_IDLE;
				end
				bit_cnt <= bit_cnt + 5'd1;
			end
			default: begin
				state <= ACD_IDLE;
			end
			endcase
		end
	end

	// write data is gathered in a 24-bit shifter
	logic [23:0] wr_acc;
	logic [23:0] next_wr;
	assign next_wr = {wr_acc[22:0], din};
	always_ff @(posedge sys_clk) begin
		if (rst || cs_n || state != ACD_WR) begin
			wr_acc <= 24'h00_0000;
		end else if (rise) begin
			wr_acc <= next_wr;
		end
	end
	logic wr_last;
	assign wr_last = rise && state == ACD_WR && bit_cnt == width_sel - 5'd1;

	// writable registers; status and data writes fall through untouched
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			control_one <= `ACD_RST_CONVERTER_CONTROL_ONE;
			gpio_ctrl <= `ACD_RST_GPIO_DIRECTION_VALUE;
			gain_and_cal_enable <= `ACD_RST_GAIN_AND_CAL_ENABLE;
			system_offset_coeff <= `ACD_RST_WIDE;
			self_offset_coeff <= `ACD_RST_WIDE;
			self_gain_coeff <= `ACD_RST_WIDE;
		end else if (wr_last) begin
			if (sel == `ACD_SEL_CONVERTER_CONTROL_ONE) begin
				control_one <= next_wr[7:0];
			end else if (sel == `ACD_SEL_GPIO_DIRECTION_VALUE) begin
				gpio_ctrl <= next_wr[7:0];
			end else if (sel == `ACD_SEL_GAIN_AND_CAL_ENABLE) begin
				gain_and_cal_enable <= next_wr[7:0];
			end else if (sel == `ACD_SEL_SOC) begin
				system_offset_coeff <= next_wr;
			end else if (sel == `ACD_SEL_SELF_OFFSET_COEFF) begin
				self_offset_coeff <= next_wr;
			end else if (sel == `ACD_SEL_SELF_GAIN_COEFF) begin
				self_gain_coeff <= next_wr;
			end
		end
	end

	// gain coefficient also saturates to full scale when calibration reports gain overrange
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			system_gain_coeff <= `ACD_RST_WIDE;
		end else if (wr_last && sel == `ACD_SEL_SGC) begin
			system_gain_coeff <= next_wr;
		end else if (cal_done && cal_gain_over) begin
			system_gain_coeff <= `ACD_SGC_MAX; // [RULE8]
		end
	end

	assign gain_sel = HAS_GAIN ? gain_and_cal_enable[7:5] : 3'h0; // [RULE7]
	assign coeff_disable = gain_and_cal_enable[4:1];

	// output shifter: load at command end, change on falling edges
	always_ff @(posedge sys_clk) begin
		if (rst || cs_n) begin
			shift_out <= 24'h00_0000;
		end else if (byte_done && state == ACD_CMD) begin
			shift_out <= read_val;
		end else if (fall && state == ACD_RD && bit_cnt != 5'd0) begin
			shift_out <= {shift_out[22:0], 1'b0}; // [RULE19]
		end
	end
	// between frames the pin shows not-ready while selected
	assign dout = (state == ACD_RD) ? shift_out[23] : !conv_status.ready;
	assign dout_oe = !cs_n;

	// action command decode
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			start_conv <= 1'b0;
			start_cal <= 1'b0;
			cal_kind <= 2'h0;
			conv_rate <= 3'h0;
			powerdown <= 1'b0;
		end else begin
			start_conv <= 1'b0;
			start_cal <= 1'b0;
			if (byte_done && state == ACD_CMD && cmd.start && !cmd.mode) begin
				if (cmd.cal != 2'h0 && !cmd.pwdn && cmd.rate == 3'h0) begin
					start_cal <= 1'b1; // [RULE3]
					cal_kind <= cmd.cal;
					powerdown <= 1'b0;
				end else if (cmd.pwdn && cmd.cal == 2'h0 && cmd.rate == 3'h0) begin
					powerdown <= 1'b1; // [RULE4]
				end else if (cmd.cal == 2'h0 && !cmd.pwdn) begin
					start_conv <= 1'b1; // [RULE5]
					conv_rate <= cmd.rate;
					powerdown <= 1'b0;
				end
			end
		end
	end

	logic wr_rd_done;
	assign wr_rd_done = rise && state == ACD_RD && sel == `ACD_SEL_DATA
		&& bit_cnt == 5'd23;
	assign data_read_done = wr_rd_done;

	// status flags; a new result wins over a clearing read
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			conv_status <= acd_status_s'(`ACD_RST_STATUS); // [RULE16]
			conversion_result <= `ACD_RST_WIDE;
			pend_rate <= 3'h0;
			busy_cal <= 1'b0;
			read_seen <= 1'b0;
		end else begin
			if (start_conv) begin
				pend_rate <= conv_rate;
				if (read_seen) begin
					conv_status.ready <= 1'b0; // [RULE14]
				end
				read_seen <= 1'b0;
			end
			if (powerdown) begin
				conv_status.busy <= 1'b0;
			end
			if (data_read_done) begin
				if (conv_status.busy && !busy_cal) begin
					conv_status.ready <= 1'b0; // [RULE15]
				end else begin
					read_seen <= 1'b1; // [RULE14]
				end
			end
			if (cal_done) begin
				busy_cal <= 1'b0;
				conv_status.busy <= 1'b0; // [RULE12]
				conv_status.rate <= 3'h0; // [RULE9]
				if (cal_kind == `ACD_CAL_SYSGAIN) begin
					conv_status.cal_over <= cal_gain_over; // [RULE8]
				end
			end
			if (mod_done) begin
				conv_status.ready <= 1'b1; // [RULE13]
				conv_status.rate <= pend_rate; // [RULE9]
				conv_status.busy <= !control_one[1];
				conv_status.over <= mod_over; // [RULE10]
				conv_status.under <= mod_under; // [RULE11]
				read_seen <= 1'b0;
				if (mod_over) begin
					conversion_result <= max_code; // [RULE10]
				end else if (mod_under) begin
					conversion_result <= 24'h00_0000; // [RULE11]
				end else begin
					conversion_result <= mod_result;
				end
			end
			// a start beside a completion keeps the modulator busy
			if (start_conv || start_cal) begin
				conv_status.busy <= 1'b1; // [RULE12]
			end
			if (start_cal) begin
				busy_cal <= 1'b1;
			end
		end
	end

	chk_ready_on_result: assert property (@(posedge sys_clk) disable iff (rst)
		mod_done |=> conv_status.ready) // [RULE13]
		else $error("ready not set after result");
	chk_over_clip: assert property (@(posedge sys_clk) disable iff (rst)
		mod_done && mod_over |=> conversion_result == max_code
		&& conv_status.over) // [RULE10]
		else $error("overrange result not clipped");
	chk_under_clip: assert property (@(posedge sys_clk) disable iff (rst)
		mod_done && mod_under && !mod_over |=> conversion_result == 24'h0
		&& conv_status.under) // [RULE11]
		else $error("underrange result not clipped");
	chk_busy_on_start: assert property (@(posedge sys_clk) disable iff (rst)
		(start_conv || start_cal) && !powerdown
		|=> conv_status.busy) // [RULE12]
		else $error("busy not raised at start");
	chk_rate_follows: assert property (@(posedge sys_clk) disable iff (rst)
		mod_done && !cal_done |=> conv_status.rate == $past(pend_rate)) // [RULE9]
		else $error("status rate not from held result");
	chk_sgc_saturate: assert property (@(posedge sys_clk) disable iff (rst)
		cal_done && cal_gain_over && !wr_last
		|=> system_gain_coeff == `ACD_SGC_MAX) // [RULE8]
		else $error("gain coefficient not saturated");
	chk_gain_variant: assert property (@(posedge sys_clk) disable iff (rst)
		!HAS_GAIN |-> gain_sel == 3'h0) // [RULE7]
		else $error("gain bits used on plain variant");
	chk_status_ro: assert property (@(posedge sys_clk) disable iff (rst)
		wr_last && sel == `ACD_SEL_STATUS && !mod_done && !cal_done
		&& !start_conv && !start_cal && !data_read_done
		|=> $stable(conv_status)) // [RULE21]
		else $error("status changed by a write");
	chk_read_clear: assert property (@(posedge sys_clk) disable iff (rst)
		data_read_done && conv_status.busy && !busy_cal && !mod_done
		|=> !conv_status.ready) // [RULE15]
		else $error("ready not cleared after read");
endmodule
`default_nettype wire

// File: testbench/acd_host_model.sv
// host side model: serial link master for the command decoder
// assumes the bench calls xfer; serial clock idles high
`timescale 1ns/1ns
`default_nettype none
module acd_host_model (
	output logic sclk_pin,
	output logic cs_n_pin,
	output logic din_pin,
	input wire logic dout,
	input wire logic dout_oe
);
	initial begin
		sclk_pin = 1'b1;
		cs_n_pin = 1'b1;
		din_pin = 1'b0;
	end
	// clock stands still between frames; din flips so no stale bit shows
	task automatic xfer(input logic [7:0] cmd, input int nb,
		input logic [23:0] wd, output logic [23:0] rd);
		logic [31:0] sh;
		sh = {cmd, wd << (24 - nb)};
		rd = 24'h00_0000;
		cs_n_pin = 1'b0;
		#400;
		for (int i = 0; i < 8 + nb; i++) begin
			sclk_pin = 1'b0;
			din_pin = sh[31];
			sh = sh << 1;
			#400;
			if (i >= 8)
				rd = {rd[22:0], dout_oe ? dout : 1'bx};
			sclk_pin = 1'b1;
			#400;
		end
		// let the last rising edge through the synchronisers first
		#400;
		cs_n_pin = 1'b1;
		din_pin = ~din_pin;
		#800;
	endtask
endmodule
`default_nettype wire

// File: testbench/tb_adc_command_decode_and_status.sv
// bench for the command decoder: host model on the link, bench as modulator
// assumes acd_core with synchronised pins and 10 MHz sys_clk
`timescale 1ns/1ns
`default_nettype none
module tb_adc_command_decode_and_status;
	import acd_pkg::*;
	localparam int RES = 18;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic mod_done = 1'b0;
	logic mod_over = 1'b0;
	logic mod_under = 1'b0;
	logic cal_done = 1'b0;
	logic cal_gain_over = 1'b0;
	logic [23:0] mod_result = 24'h00_0000;
	wire logic sclk_pin, cs_n_pin, din_pin, dout, dout_oe;
	wire logic start_conv, start_cal, powerdown;
	wire logic [1:0] cal_kind;
	wire logic [2:0] conv_rate, gain_sel;
	wire logic [7:0] control_one, gpio_ctrl;
	wire logic [3:0] coeff_disable;
	wire logic [2:0] gain_sel_plain;
	int err_total = 0;
	int n_checks = 0;
	int n_conv = 0;
	int n_cal = 0;
	logic [2:0] last_rate;
	logic [1:0] last_kind;
	logic [23:0] rd;
	always #50 sys_clk = ~sys_clk;
	acd_core #(.HAS_GAIN(1'b1), .RES_BITS(RES)) dut_u (
		.sys_clk(sys_clk), .rst(rst), .sclk_pin(sclk_pin),
		.cs_n_pin(cs_n_pin), .din_pin(din_pin), .dout(dout),
		.dout_oe(dout_oe), .start_conv(start_conv), .start_cal(start_cal),
		.cal_kind(cal_kind), .conv_rate(conv_rate), .powerdown(powerdown),
		.mod_done(mod_done), .mod_result(mod_result), .mod_over(mod_over),
		.mod_under(mod_under), .cal_done(cal_done),
		.cal_gain_over(cal_gain_over), .control_one(control_one),
		.gpio_ctrl(gpio_ctrl), .gain_sel(gain_sel),
		.coeff_disable(coeff_disable));
	// variant without gain: shares the link and modulator, only gain watched
	acd_core #(.HAS_GAIN(1'b0), .RES_BITS(RES)) dut_plain_u (
		.sys_clk(sys_clk), .rst(rst), .sclk_pin(sclk_pin),
		.cs_n_pin(cs_n_pin), .din_pin(din_pin), .dout(),
		.dout_oe(), .start_conv(), .start_cal(),
		.cal_kind(), .conv_rate(), .powerdown(),
		.mod_done(mod_done), .mod_result(mod_result), .mod_over(mod_over),
		.mod_under(mod_under), .cal_done(cal_done),
		.cal_gain_over(cal_gain_over), .control_one(),
		.gpio_ctrl(), .gain_sel(gain_sel_plain),
		.coeff_disable());
	acd_host_model host_u (.sclk_pin(sclk_pin), .cs_n_pin(cs_n_pin),
		.din_pin(din_pin), .dout(dout), .dout_oe(dout_oe));
	// start pulses stand one cycle, so they are caught here
	always @(posedge sys_clk) begin
		if (start_conv === 1'b1) begin
			n_conv++;
			last_rate = conv_rate;
		end
		if (start_cal === 1'b1) begin
			n_cal++;
			last_kind = cal_kind;
		end
	end
	task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wrap_up();
		if (err_total == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic rd_reg(input logic [3:0] sel, output logic [23:0] v);
		host_u.xfer({3'b110, sel, 1'b1}, sel < 4 ? 8 : 24, 24'h0, v);
	endtask
	task automatic wr_reg(input logic [3:0] sel, input logic [23:0] v);
		logic [23:0] d;
		host_u.xfer({3'b110, sel, 1'b0}, sel < 4 ? 8 : 24, v, d);
	endtask
	task automatic act(input logic [7:0] cmd);
		logic [23:0] d;
		host_u.xfer(cmd, 0, 24'h0, d);
	endtask
	task automatic mod_pulse(input logic [23:0] r, input logic o, u);
		@(posedge sys_clk);
		#5;
		mod_result = r;
		mod_over = o;
		mod_under = u;
		mod_done = 1'b1;
		@(posedge sys_clk);
		#5;
		mod_done = 1'b0;
		repeat (2) @(posedge sys_clk);
		#5;
	endtask
	task automatic cal_pulse(input logic g);
		@(posedge sys_clk);
		#5;
		cal_gain_over = g;
		cal_done = 1'b1;
		@(posedge sys_clk);
		#5;
		cal_done = 1'b0;
		repeat (2) @(posedge sys_clk);
		#5;
	endtask
	task automatic st(input logic [7:0] exp);
		logic [23:0] v;
		rd_reg(4'h0, v);
		cmp(v, {16'h0, exp});
	endtask
	task automatic t_reset();
		logic [23:0] exp [9];
		exp = '{24'h02, 24'h02, 24'h0f, 24'h1e, 0, 0, 0, 0, 0};
		exp[0] = 24'h00;
		for (int s = 0; s < 9; s++) begin
			rd_reg(4'(s), rd);
			cmp(rd, exp[s]);
		end
		cmp({16'h0, control_one}, 24'h02);
		cmp({16'h0, gpio_ctrl}, 24'h0f);
		cmp({20'h0, coeff_disable}, 24'hf);
	endtask
	task automatic t_regs();
		wr_reg(4'h3, 24'hb4);
		cmp({21'h0, gain_sel}, 24'h5);
		cmp({20'h0, coeff_disable}, 24'ha);
		cmp({21'h0, gain_sel_plain}, 24'h0);
		wr_reg(4'h1, 24'h4b);
		wr_reg(4'h2, 24'hf1);
		wr_reg(4'h6, 24'h65_4321);
		wr_reg(4'h7, 24'h0f_1e2d);
		wr_reg(4'h4, 24'h55_5555);
		cmp({16'h0, control_one}, 24'h4b);
		cmp({16'h0, gpio_ctrl}, 24'hf1);
		rd_reg(4'h1, rd);
		cmp(rd, 24'h4b);
		rd_reg(4'h6, rd);
		cmp(rd, 24'h65_4321);
		rd_reg(4'h7, rd);
		cmp(rd, 24'h0f_1e2d);
		rd_reg(4'h4, rd);
		cmp(rd, 24'h00_0000);
		wr_reg(4'h5, 24'h12_3456);
		wr_reg(4'h8, 24'ha5_5a3c);
		wr_reg(4'h0, 24'hff);
		host_u.xfer(8'hd2, 24, 24'hff_ffff, rd);
		rd_reg(4'h5, rd);
		cmp(rd, 24'h12_3456);
		rd_reg(4'h8, rd);
		cmp(rd, 24'ha5_5a3c);
		st(8'h00);
	endtask
	task automatic t_conv();
		int c;
		for (int r = 0; r < 8; r++) begin
			c = n_conv;
			act({5'b10000, 3'(r)});
			cmp(24'(n_conv - c), 24'h1);
			cmp({21'h0, last_rate}, 24'(r));
			mod_pulse(24'h00_0010, 1'b0, 1'b0);
		end
		st({1'b0, 3'd7, 4'b0001});
		act(8'h85);
		st({1'b0, 3'd7, 4'b0011});
		rd_reg(4'h4, rd);
		st({1'b0, 3'd7, 4'b0010});
		mod_pulse(24'h01_2345, 1'b0, 1'b0);
		st({1'b0, 3'd5, 4'b0001});
		rd_reg(4'h4, rd);
		cmp(rd, 24'h01_2345);
		st({1'b0, 3'd5, 4'b0001});
		act(8'h82);
		st({1'b0, 3'd5, 4'b0010});
	endtask
	task automatic t_range();
		mod_pulse(24'h0f_ffff, 1'b1, 1'b0);
		st({1'b0, 3'd2, 4'b1001});
		rd_reg(4'h4, rd);
		cmp(rd, 24'((1 << RES) - 1));
		act(8'h82);
		mod_pulse(24'hff_0000, 1'b0, 1'b1);
		st({1'b0, 3'd2, 4'b0101});
		rd_reg(4'h4, rd);
		cmp(rd, 24'h00_0000);
		act(8'h82);
		mod_pulse(24'h00_0100, 1'b0, 1'b0);
		st({1'b0, 3'd2, 4'b0001});
	endtask
	task automatic t_cal();
		int c;
		for (int k = 1; k < 4; k++) begin
			c = n_cal;
			act({2'b10, 2'(k), 4'b0000});
			cmp(24'(n_cal - c), 24'h1);
			cmp({22'h0, last_kind}, 24'(k));
			rd_reg(4'h0, rd);
			cmp({23'h0, rd[1]}, 24'h1);
			cal_pulse(k == 3);
		end
		rd_reg(4'h0, rd);
		cmp({20'h0, rd[7:4]}, 24'h8);
		cmp({23'h0, rd[1]}, 24'h0);
		rd_reg(4'h6, rd);
		cmp(rd, 24'hff_ffff);
	endtask
	task automatic t_pwdn();
		int c;
		c = n_conv;
		act(8'h88);
		cmp({23'h0, powerdown}, 24'h1);
		act(8'h05);
		cmp(24'(n_conv - c), 24'h0);
		act(8'h80);
		cmp({23'h0, powerdown}, 24'h0);
		cmp(24'(n_conv - c), 24'h1);
		mod_pulse(24'h00_0001, 1'b0, 1'b0);
	endtask
	initial begin
		repeat (3) @(posedge sys_clk);
		#5;
		rst = 1'b0;
		repeat (5) @(posedge sys_clk);
		// offset keeps link edges off the sys_clk edges
		#5;
		t_reset();
		t_regs();
		t_conv();
		t_range();
		t_cal();
		t_pwdn();
		wrap_up();
	end
	initial begin
		#5000000;
		err_total++;
		wrap_up();
	end
endmodule
`default_nettype wire
